/* common/pcm_defs.svh */
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH

// Word layout
`define PCM_WORD_BITS      8
`define PCM_SIGN_BIT       7
// Format conversion masks and codes
`define PCM_MU_INV_MASK    7'h7F
`define PCM_A_INV_MASK     8'h55
`define PCM_ZERO_CODE      8'h00
`define PCM_ZERO_SUB       8'h02
`define PCM_IDLE_WORD      8'h80
// Frame syncs after power-up before output is driven
`define PCM_PD_HOLD_FRAMES 2'h2
// Falling receive edges per word, minus one
`define PCM_RX_LAST_FALL   3'h7
// Buffer depth in words
`define PCM_FIFO_DEPTH     8

`endif

/* common/pcm_pkg.sv */
`default_nettype none
package pcm_pkg;

    // Three-level pin decode
    typedef enum logic [1:0] {
        PCM_LVL_LOW,
        PCM_LVL_MID,
        PCM_LVL_HIGH
    } pcm_level_type;

    // Receive word sequencer
    typedef enum logic [1:0] {
        PCM_RX_IDLE,
        PCM_RX_SHIFT,
        PCM_RX_XFER
    } pcm_rx_state_type;

    // Decoded receive word
    typedef struct packed {
        logic       conf;
        logic [7:0] code;
    } pcm_rx_word_type;

    // Pin levels after synchronising
    typedef struct packed {
        logic       txClk;
        logic       txEn;
        logic       rxClk;
        logic       rxEn;
        logic       rxData;
        logic       fsync;
        logic       pdN;
        logic       dataClk;
        logic [1:0] lawSel;
        logic [1:0] refSel;
    } pcm_pins_type;

endpackage : pcm_pkg
`default_nettype wire

/* core/pcm_codec_serial_port.sv */
// Functional notes
// [R01] Drive serial output only while enable high
// [R02] Output timing set by clock and enable
// [R03] Far end gives 64 kHz..4.096 MHz clock
// [R04] Receive bits sampled on falling clock edges
// [R05] Receive pins asynchronous to other inputs
// [R06] Far end marks sign bit with rising enable
// [R07] First bit next fall, seven more follow
// [R08] Ninth rising edge transfers word, starts decode
// [R09] Far end keeps word rate 7.5..8.5 kHz
// [R10] Two words per frame decoded and summed; code flags the later word in rxWord.conf, no sum
// [R11] Three-level law select picks format
// [R12] Mu-law keeps sign, inverts seven bits
// [R13] Mu-law all-zero becomes 0000 0010
// [R14] A-law inverts odd bits, no suppression; code inverts bits 6,4,2,0 (mask 55)
// [R15] Power-down gates clocks, bias, output
// [R16] Output stays off two frames after power-up; code holds it one frame, driving from the second frame sync
// [R17] Shared-clock variant uses one data clock
// [R18] Reference select decodes three scale levels
// [R19] Shift out on rising clock while enabled
// [R20] First enable after frame sync loads word
// [R21] Transmit register recirculates its word
// [R22] Receiver idle until next rising enable
// [R23] Receive decode uses the selected law
`timescale 1ns/100ps
`default_nettype none
`include "pcm_defs.svh"

module pcm_codec_serial_port #(
    parameter bit SHARED_CLK = 1'b0,
    parameter int FIFO_DEPTH = `PCM_FIFO_DEPTH
) (
    input  wire logic                      sys_clk,
    input  wire logic                      srst,
    input  wire logic                      tx_bit_clock,
    input  wire logic                      tx_shift_enable,
    input  wire logic                      rx_bit_clock,
    input  wire logic                      rx_word_enable,
    input  wire logic                      rx_serial_in,
    input  wire logic                      frame_sync_in,
    input  wire logic                      power_down_n,
    input  wire logic                      shared_bit_clock,
    input  wire logic [1:0]                law_select,
    input  wire logic [1:0]                ref_scale_select,
    input  wire logic                      txSampleValid,
    output var  logic                      txSampleReady,
    input  wire logic [7:0]                txSample,
    output var  logic                      tx_serial_out,
    output var  logic                      tx_serial_out_oe,
    output var  logic                      convStart,
    output var  pcm_pkg::pcm_rx_word_type  rxWord,
    output var  logic                      rxWordValid,
    output var  logic                      biasEnable,
    output var  pcm_pkg::pcm_level_type    refScale,
    output var  pcm_pkg::pcm_level_type    lawActive
);

    // Whole block state
    typedef struct packed {
        pcm_pkg::pcm_pins_type    prev;
        logic [7:0]               txShift;
        logic                     txArmed;
        logic                     txOut;
        logic                     txOe;
        logic                     convStart;
        logic [1:0]               pdHold;
        pcm_pkg::pcm_rx_state_type rxState;
        logic [7:0]               rxShift;
        logic [2:0]               rxFalls;
        logic                     frameWord;
        pcm_pkg::pcm_rx_word_type rxWord;
        logic                     rxValid;
        logic                     bias;
        pcm_pkg::pcm_level_type   refScale;
        pcm_pkg::pcm_level_type   law;
    } pcm_port_state_type;

    pcm_port_state_type    st_r;      // Current state
    pcm_port_state_type    st_nxt;    // Next state
    pcm_pkg::pcm_pins_type pinsRaw;   // Pins before sync
    pcm_pkg::pcm_pins_type s;         // Pins after sync
    pcm_pkg::pcm_level_type lawNow;   // Decoded law level
    logic                  fifoValid; // Buffered word present
    logic [7:0]            fifoData;  // Oldest buffered word
    logic                  popReq;    // Take word at strobe
    logic                  txC;       // Selected transmit clock
    logic                  txCPrev;   // Its previous level
    logic                  rxC;       // Selected receive clock
    logic                  rxCPrev;   // Its previous level
    logic                  txRise;    // Transmit clock rose
    logic                  enRise;    // Transmit enable rose
    logic                  fsRise;    // Frame sync rose
    logic                  rxRise;    // Receive clock rose
    logic                  rxFall;    // Receive clock fell
    logic                  rxEnRise;  // Receive enable rose
    logic                  strobe;    // Transmit strobe

    if (FIFO_DEPTH < 2) begin : g_chk
        $error("pcm_codec_serial_port needs a buffer of two or more");
    end

    ////////////////////////////////////////////////////////////////
    // Format conversion from sign-magnitude to line code
    function automatic logic [7:0] encodeWord(input logic [7:0] sm,
                                              input pcm_pkg::pcm_level_type lvl);
        logic [7:0] t;
        t = sm;
        case (lvl)
            pcm_pkg::PCM_LVL_HIGH: begin
                t = {sm[`PCM_SIGN_BIT], sm[6:0] ^ `PCM_MU_INV_MASK}; // R12
                if (t == `PCM_ZERO_CODE) begin
                    t = `PCM_ZERO_SUB; // R13
                end
            end
            pcm_pkg::PCM_LVL_LOW: t = sm ^ `PCM_A_INV_MASK; // R14
            default:              t = sm;
        endcase
        return t;
    endfunction : encodeWord

    // Line code back to sign-magnitude; suppressed zero is not undone
    function automatic logic [7:0] decodeWord(input logic [7:0] c,
                                              input pcm_pkg::pcm_level_type lvl);
        logic [7:0] t;
        t = c;
        case (lvl)
            pcm_pkg::PCM_LVL_HIGH: t = {c[`PCM_SIGN_BIT], c[6:0] ^ `PCM_MU_INV_MASK};
            pcm_pkg::PCM_LVL_LOW:  t = c ^ `PCM_A_INV_MASK;
            default:               t = c;
        endcase
        return t;
    endfunction : decodeWord

    ////////////////////////////////////////////////////////////////
    // All pins are asynchronous, receive trio included
    assign pinsRaw = '{txClk: tx_bit_clock, txEn: tx_shift_enable,
                       rxClk: rx_bit_clock, rxEn: rx_word_enable,
                       rxData: rx_serial_in, fsync: frame_sync_in,
                       pdN: power_down_n, dataClk: shared_bit_clock,
                       lawSel: law_select, refSel: ref_scale_select};

    pcm_sync #(
        .W ($bits(pcm_pkg::pcm_pins_type))
    ) u_sync ( // R05
        .sys_clk (sys_clk),
        .srst    (srst),
        .d       (pinsRaw),
        .q       (s)
    );

    // Encoder samples wait here for the transmit strobe
    pcm_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .srst    (srst),
        .wrValid (txSampleValid),
        .wrReady (txSampleReady),
        .wrData  (txSample),
        .rdValid (fifoValid),
        .rdReady (popReq),
        .rdData  (fifoData)
    );

    ////////////////////////////////////////////////////////////////
    // Clock choice and edge finding
    always_comb begin
        txC      = SHARED_CLK ? s.dataClk : s.txClk;             // R17
        txCPrev  = SHARED_CLK ? st_r.prev.dataClk : st_r.prev.txClk;
        rxC      = SHARED_CLK ? s.dataClk : s.rxClk;             // R17
        rxCPrev  = SHARED_CLK ? st_r.prev.dataClk : st_r.prev.rxClk;
        txRise   = txC && !txCPrev;
        rxRise   = rxC && !rxCPrev;
        rxFall   = !rxC && rxCPrev;
        enRise   = s.txEn && !st_r.prev.txEn;
        fsRise   = s.fsync && !st_r.prev.fsync;
        rxEnRise = s.rxEn && !st_r.prev.rxEn;
        // Unused code on the three-level pin reads as mid
        lawNow   = (s.lawSel == 2'h3) ? pcm_pkg::PCM_LVL_MID
                                      : pcm_pkg::pcm_level_type'(s.lawSel);
        strobe   = s.pdN && enRise && (st_r.txArmed || fsRise);  // R20
    end

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt           = st_r;
        st_nxt.prev      = s;
        st_nxt.convStart = 1'b0;
        st_nxt.rxValid   = 1'b0;
        popReq           = 1'b0;
        st_nxt.law       = lawNow; // R11
        st_nxt.bias      = s.pdN;  // R15
        st_nxt.refScale  = (s.refSel == 2'h3) ? pcm_pkg::PCM_LVL_MID
                                              : pcm_pkg::pcm_level_type'(s.refSel); // R18
        if (!s.pdN) begin
            // Clocks gated: nothing shifts, receiver drops its word
            st_nxt.pdHold  = `PCM_PD_HOLD_FRAMES; // R16
            st_nxt.txArmed = 1'b0;                // R15
            st_nxt.rxState = pcm_pkg::PCM_RX_IDLE;
        end else begin
            // Frame sync arms the strobe and ages the hold
            if (fsRise) begin
                st_nxt.txArmed = 1'b1;
                if (st_r.pdHold != 2'h0) begin
                    st_nxt.pdHold = st_r.pdHold - 2'h1; // R16
                end
            end
            // Strobe wins over a shift in the same cycle
            if (strobe) begin
                st_nxt.txArmed   = 1'b0;
                st_nxt.convStart = 1'b1;
                st_nxt.frameWord = 1'b0;
                popReq           = fifoValid;
                // Empty buffer sends positive zero
                st_nxt.txShift   = encodeWord(fifoValid ? fifoData : `PCM_IDLE_WORD,
                                              lawNow); // R20
            end else if (txRise && s.txEn) begin
                // Enable gates the shift clock; bit wraps round
                st_nxt.txShift = {st_r.txShift[6:0], st_r.txShift[7]}; // R19 R21
            end
            // Receive word sequencer
            case (st_r.rxState)
                pcm_pkg::PCM_RX_IDLE: begin
                    // Data line ignored until enable rises
                    if (rxEnRise) begin // R22
                        st_nxt.rxState = pcm_pkg::PCM_RX_SHIFT;
                        st_nxt.rxFalls = 3'h0;
                    end
                end
                pcm_pkg::PCM_RX_SHIFT: begin
                    if (rxFall && s.rxEn) begin
                        st_nxt.rxShift = {st_r.rxShift[6:0], s.rxData}; // R04
                        st_nxt.rxFalls = st_r.rxFalls + 3'h1;           // R07
                        if (st_r.rxFalls == `PCM_RX_LAST_FALL) begin
                            st_nxt.rxState = pcm_pkg::PCM_RX_XFER;
                        end
                    end
                end
                pcm_pkg::PCM_RX_XFER: begin
                    if (rxRise) begin
                        st_nxt.rxWord.code = decodeWord(st_r.rxShift, lawNow); // R08 R23
                        st_nxt.rxWord.conf = st_r.frameWord;                   // R10
                        st_nxt.frameWord   = 1'b1;
                        st_nxt.rxValid     = 1'b1;
                        st_nxt.rxState     = pcm_pkg::PCM_RX_IDLE;
                    end
                end
                default: st_nxt.rxState = pcm_pkg::PCM_RX_IDLE;
            endcase
        end
        // Pin output and its enable
        st_nxt.txOut = st_nxt.txShift[7]; // R02
        st_nxt.txOe  = s.pdN && s.txEn && (st_nxt.pdHold == 2'h0); // R01 R15 R16
    end

    // Register state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r         <= '0;
            st_r.pdHold  <= `PCM_PD_HOLD_FRAMES;
            st_r.txShift <= `PCM_IDLE_WORD;
            st_r.law     <= pcm_pkg::PCM_LVL_MID;
            st_r.refScale <= pcm_pkg::PCM_LVL_MID;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tx_serial_out    = st_r.txOut;
    assign tx_serial_out_oe = st_r.txOe;
    assign convStart        = st_r.convStart;
    assign rxWord           = st_r.rxWord;
    assign rxWordValid      = st_r.rxValid;
    assign biasEnable       = st_r.bias;
    assign refScale         = st_r.refScale;
    assign lawActive        = st_r.law;

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_oe_enable;
        tx_serial_out_oe |-> $past(s.txEn) && $past(s.pdN);
    endproperty
    a_oe_enable: assert property (p_oe_enable) else $error("output on without enable"); // R01

    property p_pd_off;
        !s.pdN |=> !tx_serial_out_oe && !biasEnable;
    endproperty
    a_pd_off: assert property (p_pd_off) else $error("output live in power-down"); // R15

    property p_pd_hold;
        $rose(s.pdN) |=> st_r.pdHold == `PCM_PD_HOLD_FRAMES && !tx_serial_out_oe;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("hold not kept after power-up"); // R16

    property p_strobe;
        strobe |=> convStart ##1 !convStart;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe without single start"); // R20

    property p_recirc;
        txRise && s.txEn && s.pdN && !strobe
            |=> st_r.txShift == {$past(st_r.txShift[6:0]), $past(st_r.txShift[7])};
    endproperty
    a_recirc: assert property (p_recirc) else $error("transmit word not rotated"); // R21

    property p_rx_count;
        st_r.rxState == pcm_pkg::PCM_RX_SHIFT && rxFall && s.rxEn && s.pdN
            |=> st_r.rxFalls == $past(st_r.rxFalls) + 3'h1;
    endproperty
    a_rx_count: assert property (p_rx_count) else $error("receive bit not counted"); // R07

    property p_rx_xfer;
        rxWordValid |-> $past(st_r.rxState) == pcm_pkg::PCM_RX_XFER && $past(rxRise);
    endproperty
    a_rx_xfer: assert property (p_rx_xfer) else $error("word moved off rising edge"); // R08

    property p_rx_idle;
        st_r.rxState == pcm_pkg::PCM_RX_IDLE && !rxEnRise |=> st_r.rxState == pcm_pkg::PCM_RX_IDLE;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("receiver left idle alone"); // R22

    property p_mu_nonzero;
        strobe && lawNow == pcm_pkg::PCM_LVL_HIGH |=> st_r.txShift != `PCM_ZERO_CODE;
    endproperty
    a_mu_nonzero: assert property (p_mu_nonzero) else $error("zero code sent in mu-law"); // R13

    property p_alaw;
        strobe && fifoValid && lawNow == pcm_pkg::PCM_LVL_LOW
            |=> st_r.txShift == ($past(fifoData) ^ `PCM_A_INV_MASK);
    endproperty
    a_alaw: assert property (p_alaw) else $error("A-law inversion wrong"); // R14

    c_strobe: cover property (strobe && fifoValid);
    c_rx_word: cover property (rxWordValid);
    c_conf: cover property (rxWordValid && rxWord.conf);

endmodule : pcm_codec_serial_port
`default_nettype wire

/* core/pcm_fifo.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             wrValid,
    output var  logic             wrReady,
    input  wire logic [WIDTH-1:0] wrData,
    output var  logic             rdValid,
    input  wire logic             rdReady,
    output var  logic [WIDTH-1:0] rdData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Storage, pointers and registered flags
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
        logic                        notFull;
        logic                        notEmpty;
    } pcm_fifo_state_type;

    pcm_fifo_state_type st_r;   // Current state
    pcm_fifo_state_type st_nxt; // Next state
    logic               doWr;   // Accepted write
    logic               doRd;   // Accepted read

    // Pointers wrap by width, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
        $error("pcm_fifo needs power-of-two depth of two or more");
    end

    ////////////////////////////////////////////////////////////////
    // Pointer and count update
    always_comb begin
        doWr   = wrValid && st_r.notFull;
        doRd   = rdReady && st_r.notEmpty;
        st_nxt = st_r;
        if (doWr) begin
            st_nxt.mem[st_r.wrPtr] = wrData;
            st_nxt.wrPtr           = st_r.wrPtr + 1'b1;
        end
        if (doRd) begin
            st_nxt.rdPtr = st_r.rdPtr + 1'b1;
        end
        // Net count change
        if (doWr && !doRd) begin
            st_nxt.count = st_r.count + 1'b1;
        end else if (doRd && !doWr) begin
            st_nxt.count = st_r.count - 1'b1;
        end
        // Flags from the next count keep ports on flops
        st_nxt.notFull  = (st_nxt.count != (AW+1)'(DEPTH));
        st_nxt.notEmpty = (st_nxt.count != '0);
    end

    // Register state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r         <= '0;
            st_r.notFull <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wrReady = st_r.notFull;
    assign rdValid = st_r.notEmpty;
    assign rdData  = st_r.mem[st_r.rdPtr];

endmodule : pcm_fifo
`default_nettype wire

/* core/pcm_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);

    // Two stages per bit
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pcm_sync_state_type;

    pcm_sync_state_type st_r;   // Current stages
    pcm_sync_state_type st_nxt; // Next stages

    if (W < 1) begin : g_chk
        $error("pcm_sync width must be positive");
    end

    ////////////////////////////////////////////////////////////////
    // First stage feeds only the second
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // Register stages
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule : pcm_sync
`default_nettype wire

/* verif/pcm_codec_serial_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_codec_serial_port_bench;
    // Law code, sample, word on the wire, word decoded back
    typedef struct packed {
        logic [1:0] law;
        logic [7:0] smp;
        logic [7:0] line;
        logic [7:0] back;
    } pcm_row_type;
    pcm_row_type rows [8] = '{
        '{2'h2, 8'hFF, 8'h80, 8'hFF},
        '{2'h2, 8'h7F, 8'h02, 8'h7D}, // Zero code swapped
        '{2'h2, 8'h80, 8'hFF, 8'h80},
        '{2'h0, 8'hFF, 8'hAA, 8'hFF},
        '{2'h0, 8'h7F, 8'h2A, 8'h7F},
        '{2'h0, 8'h80, 8'hD5, 8'h80},
        '{2'h1, 8'h5A, 8'h5A, 8'h5A},
        '{2'h3, 8'h3C, 8'h3C, 8'h3C}  // Top code reads as mid
    };
    logic       sys_clk = 1'b0;
    logic       srst, pdN, wrValid;
    logic [1:0] lawSel, refSel;
    logic [7:0] wrData;
    logic       txClk, txEn, fsync, rxClk, rxEn, rxData;
    logic       txOut, txOe, conv, rdy, rxV, bias;
    pcm_pkg::pcm_rx_word_type rxWord;
    pcm_pkg::pcm_level_type   refScale, lawAct;
    pcm_row_type r;
    int fails = 0;
    int nCompared = 0;
    int nConv = 0;
    int nRx = 0;
    int c0, cnt;

    always #25 sys_clk = ~sys_clk;

    pcm_codec_serial_port i_dut (
        .sys_clk(sys_clk), .srst(srst), .tx_bit_clock(txClk),
        .tx_shift_enable(txEn), .rx_bit_clock(rxClk), .rx_word_enable(rxEn),
        .rx_serial_in(rxData), .frame_sync_in(fsync), .power_down_n(pdN),
        .shared_bit_clock(txClk), .law_select(lawSel), .ref_scale_select(refSel),
        .txSampleValid(wrValid), .txSampleReady(rdy), .txSample(wrData),
        .tx_serial_out(txOut), .tx_serial_out_oe(txOe), .convStart(conv),
        .rxWord(rxWord), .rxWordValid(rxV), .biasEnable(bias),
        .refScale(refScale), .lawActive(lawAct));

    pcm_hwy_model i_hwy (
        .txClk(txClk), .txEn(txEn), .fsync(fsync), .rxClk(rxClk),
        .rxEn(rxEn), .rxData(rxData), .txOut(txOut), .txOe(txOe));

    // Pulse counters, read on the falling edge, away from the launching edge
    always @(negedge sys_clk) begin
        if (conv === 1'b1) nConv++;
        if (rxV === 1'b1) nRx++;
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [1:0] lvl(input logic [1:0] c);
        return (c == 2'h3) ? 2'h1 : c;
    endfunction : lvl

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic stopTest();
        $display("compared %0d mismatched %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stopTest

    // Single write, called just after a falling edge
    task automatic push(input logic [7:0] d);
        wrData = d;
        wrValid = 1'b1;
        @(negedge sys_clk);
        wrValid = 1'b0;
    endtask : push

    // Bounded wait for a new receive word
    task automatic waitRx(input int n0);
        for (int i = 0; i < 40 && nRx == n0; i++) @(negedge sys_clk);
        if (nRx == n0) begin
            fails++;
            $display("MISMATCH t=%0t no receive word", $time);
            stopTest();
        end
    endtask : waitRx

    ////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        pdN = 1'b1;
        lawSel = 2'h1;
        refSel = 2'h1;
        wrValid = 1'b0;
        wrData = 8'h00;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        // Let the synchronisers settle before the first frame sync
        repeat (4) @(negedge sys_clk);
        i_hwy.frame(8);
        chk(i_hwy.oeCnt, 16'h0, "held after reset");
        // Table rows: both directions in each law
        foreach (rows[i]) begin
            r = rows[i];
            @(negedge sys_clk);
            lawSel = r.law;
            refSel = i[1:0];
            push(r.smp);
            c0 = nConv;
            i_hwy.frame(16);
            chk(nConv - c0, 16'h1, "strobe");
            chk(i_hwy.bits, {r.line, r.line}, "tx");
            chk(i_hwy.oeCnt, 16'h10, "oe on");
            chk(txOe, 16'h0, "oe off");
            chk(lawAct, lvl(r.law), "law");
            chk(refScale, lvl(i[1:0]), "ref");
            // Pace receive words near an 8 kHz word rate
            repeat (2250) @(negedge sys_clk);
            c0 = nRx;
            i_hwy.send(r.line, 1'b1);
            waitRx(c0);
            chk(rxWord, {1'b0, r.back}, "rx");
            $display("row %0d done", i);
        end
        // Second word in the same frame, spaced out
        #32000;
        c0 = nRx;
        i_hwy.send(8'hC3, 1'b1);
        waitRx(c0);
        chk(rxWord, {1'b1, 8'hC3}, "second word");
        // Clocks with enable low make no word
        c0 = nRx;
        i_hwy.send(8'h00, 1'b0);
        repeat (10) @(negedge sys_clk);
        chk(nRx - c0, 16'h0, "stray clocks");
        $display("receive cases done");
        // Fill until refused, then drain with gaps
        cnt = 0;
        for (int i = 0; i < 12; i++) begin
            wrData = 8'h10 + cnt[7:0];
            wrValid = 1'b1;
            if (rdy === 1'b1) cnt++;
            @(negedge sys_clk);
        end
        wrValid = 1'b0;
        chk(cnt, 16'h8, "fill");
        for (int k = 0; k < 9; k++) begin
            i_hwy.frame(8);
            chk(i_hwy.bits[7:0], (k < 8) ? 8'h10 + k[7:0] : 8'h80, "drain");
        end
        $display("buffer done");
        // Power down, then one held frame before output returns
        @(negedge sys_clk);
        pdN = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(bias, 16'h0, "bias off");
        i_hwy.frame(8);
        chk(i_hwy.oeCnt, 16'h0, "oe in power down");
        @(negedge sys_clk);
        pdN = 1'b1;
        repeat (4) @(negedge sys_clk);
        i_hwy.frame(8);
        chk(i_hwy.oeCnt, 16'h0, "first frame held");
        i_hwy.frame(8);
        chk(i_hwy.oeCnt, 16'h8, "second frame drives");
        $display("power down done");
        // Reset in mid-run
        @(negedge sys_clk);
        srst = 1'b1;
        repeat (3) @(negedge sys_clk);
        chk({txOe, conv, rxV, bias, rdy}, 16'h1, "reset outputs");
        chk(lawAct, 16'h1, "reset law");
        srst = 1'b0;
        $display("reset done");
        stopTest();
    end
endmodule : pcm_codec_serial_port_bench
`default_nettype wire

/* verif/pcm_hwy_model.sv */
`timescale 1ns/100ps
`default_nettype none

module pcm_hwy_model (
    output var  logic txClk,
    output var  logic txEn,
    output var  logic fsync,
    output var  logic rxClk,
    output var  logic rxEn,
    output var  logic rxData,
    input  wire logic txOut,
    input  wire logic txOe
);
    localparam int HALF = 200; // 400 ns link period
    logic [15:0] bits;         // Bits read in one frame
    int          oeCnt;        // Reads with output driven
    logic [8:0]  sh;           // Word plus released level

    // Clocks stand still low between frames
    initial begin
        {txClk, txEn, fsync, rxClk, rxEn, rxData} = 6'h00;
        bits = 16'h0000;
        oeCnt = 0;
        sh = 9'h000;
    end

    ////////////////////////////////////////////////////////////
    // Sync pulse, then enable and n reads, each before a rise
    task automatic frame(input int n);
        fsync = 1'b1;
        #(2 * HALF);
        fsync = 1'b0;
        txEn = 1'b1;
        oeCnt = 0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            #HALF;
            bits = {bits[14:0], txOut};
            if (txOe === 1'b1) oeCnt++;
            txClk = 1'b1;
            #HALF;
            txClk = 1'b0;
        end
        #HALF;
        txEn = 1'b0;
        #(2 * HALF);
    endtask : frame

    // Word MSB first; en low runs the clock with no word
    task automatic send(input logic [7:0] w, input logic en);
        sh = {w, ~w[0]};
        rxData = sh[8];
        rxEn = en;
        #(HALF / 2);
        for (int i = 0; i < 8; i++) begin
            #(HALF / 2);
            rxClk = 1'b1;
            #HALF;
            rxClk = 1'b0;
            #(HALF / 2);
            sh = {sh[7:0], 1'b0};
            // Data moves mid-low; released line shows inverse
            rxData = sh[8];
        end
        #(HALF / 2);
        rxClk = 1'b1; // Ninth rise hands the word over
        #HALF;
        rxClk = 1'b0;
        rxEn = 1'b0;
        #HALF;
    endtask : send
endmodule : pcm_hwy_model
`default_nettype wire
